/* core/dtf_pkg.sv */
// constants, field layouts and carrier types for the pll test and input change flag registers
package dtf_pkg;

   // register offsets on the device register port
   localparam logic [6:0] DTF_ADDR_PLL_TEST = 7'h03;
   localparam logic [6:0] DTF_ADDR_RSVD_TEST = 7'h04;
   localparam logic [6:0] DTF_ADDR_CHG_LOW = 7'h05;

   // pll test control field positions
   localparam int DTF_BIT_PHASE_ALARM = 7;
   localparam int DTF_BIT_FORCE_LOCK = 6;
   localparam int DTF_BIT_RESYNC = 4;
   localparam int DTF_BIT_TEST3 = 3;
   localparam int DTF_BIT_EDGE = 2;
   localparam int DTF_BIT_TEST1 = 1;
   localparam int DTF_BIT_TEST0 = 0;

   // change flag field positions
   localparam int DTF_BIT_IN2_DIFF = 5;
   localparam int DTF_BIT_IN1_DIFF = 4;
   localparam int DTF_BIT_IN2_SE = 3;
   localparam int DTF_BIT_IN1_SE = 2;

   // reset values
   localparam logic [7:0] DTF_PLL_TEST_RESET = 8'h14;
   localparam logic [7:0] DTF_CHG_LOW_RESET = 8'hff;
   // unused flag bits hold their reset pattern
   localparam logic [7:0] DTF_CHG_UNUSED = 8'hc3;
   localparam logic [7:0] DTF_ZERO = 8'h00;

   // validity of the four monitored input paths
   typedef struct packed {
      logic in2_diff;
      logic in1_diff;
      logic in2_se;
      logic in1_se;
   } dtf_valid_type;

   // register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } dtf_req_type;

   // controls handed to the main digital pll
   typedef struct packed {
      logic force_freq_phase;
      logic resync_analog;
      logic lock_edge_select;
   } dtf_ctrl_type;

endpackage : dtf_pkg

/* core/dtf_regs.sv */
// pll test control register, reserved test address and low input change flags
// How it works
// - force bit clear leaves lock choice automatic
// - force bit set forces frequency and phase lock
// - edge select zero falling, one rising
// - differential path validity changes set flags 5,4
// - single-ended path validity changes set flags 3,2
// - flags latch; write one clears, zero keeps
module dtf_regs
   import dtf_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire dtf_req_type req,
   input wire dtf_valid_type path_valid,
   input wire logic phase_alarm,
   output dtf_ctrl_type pll_ctrl,
   output logic [7:0] rdata,
   output logic rvalid,
   output logic [3:0] change_flags
);

   // stored part of the pll test register; bits 7 and 5 never hold state
   logic [7:0] test_reg;
   logic [7:0] test_next;

   // latched change flags, one per monitored input path
   logic [3:0] flag_reg;
   wire [3:0] flag_next;

   // validity seen at the previous edge, for transition detection
   logic [3:0] valid_prev_reg;
   logic [3:0] valid_prev_next;

   // read port holding registers; rdata keeps the last read until the next one
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic rvalid_reg;
   logic rvalid_next;

   // controls handed on to the main digital pll
   dtf_ctrl_type ctrl_reg;
   dtf_ctrl_type ctrl_next;

   // number of monitored paths, one flag each
   localparam int FLAG_N = $bits(dtf_valid_type);

   // flag reset pattern is the reset byte at positions 5 down to 2
   localparam logic [3:0] FLAG_RESET = DTF_CHG_LOW_RESET[DTF_BIT_IN2_DIFF:DTF_BIT_IN1_SE];

   // history starts all invalid, so a path valid at release flags itself
   localparam logic [3:0] VALID_RESET = DTF_ZERO[DTF_BIT_IN2_DIFF:DTF_BIT_IN1_SE];

   // pll controls reset to the fields of the register reset value, so they agree
   localparam dtf_ctrl_type CTRL_RESET = '{
      force_freq_phase: DTF_PLL_TEST_RESET[DTF_BIT_FORCE_LOCK],
      resync_analog: DTF_PLL_TEST_RESET[DTF_BIT_RESYNC],
      lock_edge_select: DTF_PLL_TEST_RESET[DTF_BIT_EDGE]
   };

   // one address decode shared by write and read paths
   function automatic logic hit(
      input logic [6:0] a,
      input logic [6:0] ref_a
   );
      hit = (a == ref_a);
   endfunction : hit

   // address selects; the test and flag selects serve both paths, the reserved select only the read path
   wire sel_test = hit(req.addr, DTF_ADDR_PLL_TEST);
   wire sel_rsvd = hit(req.addr, DTF_ADDR_RSVD_TEST);
   wire sel_chg = hit(req.addr, DTF_ADDR_CHG_LOW);

   // qualified write strobes; the reserved address gets none, so its writes vanish
   wire wr_test = req.wr && sel_test;
   wire wr_chg = req.wr && sel_chg;

   // qualified read selects
   wire rd_test = req.rd && sel_test;
   wire rd_chg = req.rd && sel_chg;
   wire rd_rsvd = req.rd && sel_rsvd;

   // write data fields of the pll test register
   wire wd_force = req.wdata[DTF_BIT_FORCE_LOCK];
   wire wd_resync = req.wdata[DTF_BIT_RESYNC];
   wire wd_test3 = req.wdata[DTF_BIT_TEST3];
   wire wd_edge = req.wdata[DTF_BIT_EDGE];
   wire wd_test1 = req.wdata[DTF_BIT_TEST1];
   wire wd_test0 = req.wdata[DTF_BIT_TEST0];

   // phase alarm is read-only and bit 5 is unused, so neither stores a write
   wire [7:0] test_wr_word = {
      1'b0,
      wd_force,
      1'b0,
      wd_resync,
      wd_test3,
      wd_edge,
      wd_test1,
      wd_test0
   };

   // the test register holds unless its own offset is written
   assign test_next = wr_test ? test_wr_word : test_reg;

   // pll sees forced lock only while set, else decides itself
   assign ctrl_next = '{
      force_freq_phase: test_next[DTF_BIT_FORCE_LOCK],
      resync_analog: test_next[DTF_BIT_RESYNC],
      lock_edge_select: test_next[DTF_BIT_EDGE]
   };

   // monitored validity as a plain vector, in2_diff down to in1_se
   wire [3:0] now_valid = path_valid;

   // clear requests as written, already in flag order
   wire [3:0] clr_field = {
      req.wdata[DTF_BIT_IN2_DIFF],
      req.wdata[DTF_BIT_IN1_DIFF],
      req.wdata[DTF_BIT_IN2_SE],
      req.wdata[DTF_BIT_IN1_SE]
   };

   // per-path transition and clear terms
   wire [3:0] chg_bit;
   wire [3:0] clr_bit;

   // all paths behave alike, so one generate body serves the four flags
   genvar g;
   generate
      for (g = 0; g < FLAG_N; g++) begin : g_flag
         // any transition, valid to invalid or back, marks a change
         assign chg_bit[g] = now_valid[g] ^ valid_prev_reg[g];
         // write one clears, write zero keeps
         assign clr_bit[g] = wr_chg && clr_field[g];
         // a change in the clearing cycle survives: set wins over clear
         assign flag_next[g] = (flag_reg[g] && !clr_bit[g]) || chg_bit[g];
      end
   endgenerate

   // history simply tracks the inputs every cycle
   assign valid_prev_next = now_valid;

   // test register view: live alarm on top, stored bits below
   wire [7:0] test_view = {phase_alarm, test_reg[DTF_BIT_FORCE_LOCK:DTF_BIT_TEST0]};

   // flags moved to positions 5..2 of the byte
   wire [7:0] flag_field = 8'(flag_reg) << DTF_BIT_IN1_SE;

   // unused flag bits keep reading their reset pattern
   wire [7:0] chg_view = DTF_CHG_UNUSED | flag_field;

   // reserved address reads zero; nothing there is ever stored
   wire [7:0] rsvd_view = DTF_ZERO;

   // built from registers, not next values: a read beside a write sees old contents
   wire [7:0] read_word = rd_test ? test_view :
                          rd_chg ? chg_view :
                          rd_rsvd ? rsvd_view : DTF_ZERO;

   // rdata only moves on a read, so software can sample it late
   assign rdata_next = req.rd ? read_word : rdata_reg;
   assign rvalid_next = req.rd;

   // test register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         test_reg <= DTF_PLL_TEST_RESET;
      end else begin
         test_reg <= test_next;
      end
   end

   // pll controls, registered so the pll sees clean levels
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= CTRL_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // change flags
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         flag_reg <= FLAG_RESET;
      end else begin
         flag_reg <= flag_next;
      end
   end

   // validity history
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         valid_prev_reg <= VALID_RESET;
      end else begin
         valid_prev_reg <= valid_prev_next;
      end
   end

   // read data
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata_reg <= DTF_ZERO;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // read strobe echo
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= rvalid_next;
      end
   end

   // outputs come straight from flops
   assign pll_ctrl = ctrl_reg;
   assign rdata = rdata_reg;
   assign rvalid = rvalid_reg;
   assign change_flags = flag_reg;

endmodule : dtf_regs

/* bench/dtf_regs_assertions.sv */
// concurrent checks on the pll test and change flag register ports
module dtf_regs_assertions import dtf_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic phase_alarm,
   input wire logic rvalid,
   input wire dtf_req_type req,
   input wire dtf_valid_type path_valid,
   input wire dtf_ctrl_type pll_ctrl,
   input wire logic [7:0] rdata,
   input wire logic [3:0] change_flags
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // write decodes for the test and flag offsets
   wire wt = req.wr && req.addr == DTF_ADDR_PLL_TEST;
   wire wf = req.wr && req.addr == DTF_ADDR_CHG_LOW;
   AST_FORCE: assert property (wt |=>
      pll_ctrl.force_freq_phase == $past(req.wdata[DTF_BIT_FORCE_LOCK])) else $error("force bit");
   AST_EDGE: assert property (wt |=>
      pll_ctrl.lock_edge_select == $past(req.wdata[DTF_BIT_EDGE])) else $error("edge bit");
   AST_DIFF_SET: assert property ($changed(path_valid.in2_diff) |=> change_flags[3])
      else $error("diff flag not set");
   AST_SE_SET: assert property ($changed(path_valid.in1_se) |=> change_flags[0])
      else $error("se flag not set");
   // a clear only lands when no validity edge competes
   AST_CLEAR: assert property (wf && req.wdata[4] && !$changed(path_valid.in1_diff)
      |=> !change_flags[2]) else $error("flag not cleared");
   AST_HOLD: assert property (change_flags[1] && !(wf && req.wdata[3]) |=> change_flags[1])
      else $error("flag lost");
   AST_READ: assert property (req.rd && req.addr == DTF_ADDR_CHG_LOW
      |=> rvalid && rdata[5:2] == $past(change_flags)) else $error("flag read");
   cover property (wf && req.wdata != DTF_ZERO);
   cover property (change_flags == 4'h0);
   cover property (pll_ctrl.force_freq_phase);
endmodule : dtf_regs_assertions
bind dtf_regs dtf_regs_assertions u_dtf_regs_assertions (.ref_clk, .rst, .phase_alarm, .rvalid,
   .req, .path_valid, .pll_ctrl, .rdata, .change_flags);

/* bench/dtf_regs_bench.sv */
// self-checking bench for the pll test and change flag registers
module dtf_regs_bench import dtf_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 0, rst = 1, phase_alarm = 0, rvalid;
   dtf_req_type req = '0;
   dtf_valid_type path_valid = '0;
   dtf_ctrl_type pll_ctrl;
   logic [7:0] rdata;
   logic [3:0] change_flags;
   int bad_count = 0, tests_run = 0, cyc = 0;
   // rows: offset, write data, read back, pll controls
   logic [25:0] rows [5] = '{{7'h03, 8'he4, 8'h44, 3'h5}, {7'h03, 8'h10, 8'h10, 3'h2},
      {7'h04, 8'h00, 8'h00, 3'h2}, {7'h05, 8'hff, 8'hc3, 3'h2}, {7'h7f, 8'h5a, 8'h00, 3'h2}};
   dtf_regs u_dtf_regs (.ref_clk, .rst, .req, .path_valid, .phase_alarm, .pll_ctrl, .rdata,
      .rvalid, .change_flags);
   initial forever #5 ref_clk = ~ref_clk;
   // cut a hang short well past the expected run
   always @(posedge ref_clk) if (++cyc > 500) begin
      bad_count++;
      test_done();
   end
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one strobe cycle, outputs looked at once settled
   task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
      @(posedge ref_clk) req <= '{w, !w, a, d};
      @(posedge ref_clk) req <= '0;
      @(negedge ref_clk);
   endtask : acc
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      acc(0, a, 8'h00);
      chk({rvalid, rdata}, {4'h1, e});
   endtask : rd
   task automatic test_done();
      $display("mismatches %0d in %0d checks", bad_count, tests_run);
      if (bad_count == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : test_done
   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 0;
      rd(DTF_ADDR_CHG_LOW, DTF_CHG_LOW_RESET);
      rd(DTF_ADDR_PLL_TEST, DTF_PLL_TEST_RESET);
      chk(pll_ctrl, 3'h3);
      foreach (rows[i]) begin
         acc(1, rows[i][25:19], rows[i][18:11]);
         rd(rows[i][25:19], rows[i][10:3]);
         chk(pll_ctrl, rows[i][2:0]);
      end
      // validity edges after a clear, then a zero write must keep them
      @(posedge ref_clk) path_valid <= 4'ha;
      phase_alarm <= 1;
      acc(1, DTF_ADDR_CHG_LOW, DTF_ZERO);
      rd(DTF_ADDR_CHG_LOW, 8'heb);
      rd(DTF_ADDR_PLL_TEST, 8'h90);
      chk(change_flags, 4'ha);
      // mid-run reset brings back reset contents; valid paths flag themselves
      @(posedge ref_clk) rst <= 1;
      @(posedge ref_clk) rst <= 0;
      rd(DTF_ADDR_CHG_LOW, DTF_CHG_LOW_RESET);
      rd(DTF_ADDR_PLL_TEST, 8'h94);
      chk(pll_ctrl, 3'h3);
      test_done();
   end
endmodule : dtf_regs_bench
